// ==== hw/tlpes_top.sv ====
// Line port of one tributary channel: primary and redundant line
// inputs, ingress rails into a two-entry buffer, egress rails out.
// Assumes the line and tributary clock and rail pins are asynchronous to core_clk and that the register
// master issues one-cycle strobes.
`timescale 1ns/1ps

module tlpes_top
  import tlpes_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              line_rx_serial_clock_diff_pri,
  input  wire logic              line_rx_serial_data_diff_pri,
  input  wire logic              line_rx_serial_clock_diff_red,
  input  wire logic              line_rx_serial_data_diff_red,
  output logic                   line_pri_strobe,
  output logic                   line_pri_bit,
  output logic                   line_red_strobe,
  output logic                   line_red_bit,
  input  wire logic              trib_rx_clock,
  input  wire logic              trib_rx_pos_rail,
  input  wire logic              trib_rx_neg_rail,
  output logic                   ing_valid,
  input  wire logic              ing_ready,
  output logic                   ing_pos,
  output logic                   ing_neg,
  input  wire logic              trib_tx_clock,
  input  wire logic              eg_valid,
  output logic                   eg_ready,
  input  wire logic              eg_pos,
  input  wire logic              eg_neg,
  output logic                   trib_tx_pos_rail,
  output logic                   trib_tx_neg_rail
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] cfg;             // Mode and edge settings
  tlpes_mode_t      mode;            // Decoded operating mode
  logic             ovf;             // Ingress overflow, sticky
  logic             und;             // Egress underrun, sticky
  logic             ent_pos [2];     // Ingress buffer, positive rail
  logic             ent_neg [2];     // Ingress buffer, negative rail
  logic [1:0]       ing_cnt;         // Ingress buffer fill
  logic [1:0]       next_cnt;        // Fill after this cycle
  logic             next_pos [2];    // Buffer contents after this cycle
  logic             next_neg [2];
  logic             push_drop;       // Push found the buffer full
  logic             pop;             // Word taken by the receiver
  logic             hold_full;       // Egress holding slot used
  logic             hold_pos;        // Egress held positive bit
  logic             hold_neg;        // Egress held negative bit
  logic             next_hold_full;  // Holding slot after this cycle
  logic             take;            // Word accepted from the sender
  logic             stat_clr_ovf;    // Software clear of overflow
  logic             stat_clr_und;    // Software clear of underrun

  tlpes_samp_if #(.W(1)) pri_if ();  // Primary line sampler
  tlpes_samp_if #(.W(1)) red_if ();  // Redundant line sampler
  tlpes_samp_if #(.W(2)) ing_if ();  // Ingress rail sampler
  tlpes_samp_if #(.W(1)) eg_if  ();  // Egress clock edge finder

  // Operating mode decoded from the settings bit
  assign mode = cfg[CFG_MODE_BIT] ? TLPES_MODE_STS1 : TLPES_MODE_DS3E3;

  // ----------------------------------------------------------------
  // Line inputs
  // ----------------------------------------------------------------
  // Both line inputs always use the rising edge
  assign pri_if.fall_sel = 1'b0;     // RULE1
  assign red_if.fall_sel = 1'b0;     // RULE2

  // Primary line input, rising edge only
  tlpes_edge_sampler #(.W(1)) u_pri (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_clk  (line_rx_serial_clock_diff_pri),
    .pin_data (line_rx_serial_data_diff_pri),
    .port     (pri_if.sampler)
  );

  // Redundant line input, same discipline
  tlpes_edge_sampler #(.W(1)) u_red (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_clk  (line_rx_serial_clock_diff_red),
    .pin_data (line_rx_serial_data_diff_red),
    .port     (red_if.sampler)
  );

  // Registered copies of both captured line streams
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_pri_strobe <= 1'h0;
      line_pri_bit    <= 1'h0;
      line_red_strobe <= 1'h0;
      line_red_bit    <= 1'h0;
    end else begin
      line_pri_strobe <= pri_if.strobe;
      line_pri_bit    <= pri_if.bits[0];
      line_red_strobe <= red_if.strobe;  // RULE2
      line_red_bit    <= red_if.bits[0];
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Writing one to a status flag bit clears it
  assign stat_clr_ovf = reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_OVF_BIT];
  assign stat_clr_und = reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_UND_BIT];

  // Settings register, rising edges and DS3/E3 after reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg <= CFG_RESET;                        // RULE11
    end else if (reg_wr && reg_addr == REG_CFG) begin
      cfg <= reg_wdata[CFG_W-1:0];             // RULE3
    end
  end

  // Read data stand for the one cycle after the read strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd && reg_addr == REG_CFG) begin
      reg_rdata <= {{(DATA_W-CFG_W){1'b0}}, cfg};
    end else if (reg_rd && reg_addr == REG_STAT) begin
      reg_rdata <= {27'h0, cfg[CFG_MODE_BIT], und, ovf, ing_cnt};
    end else begin
      reg_rdata <= '0;                         // Unmapped or idle reads zero
    end
  end

  // ----------------------------------------------------------------
  // Ingress rails
  // ----------------------------------------------------------------
  // Ingress edge choice comes straight from the settings
  assign ing_if.fall_sel = cfg[CFG_IN_FALL];   // RULE4 RULE6

  // Both rails share one sampler so they stay paired
  tlpes_edge_sampler #(.W(2)) u_ing (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_clk  (trib_rx_clock),
    .pin_data ({trib_rx_neg_rail, trib_rx_pos_rail}),
    .port     (ing_if.sampler)
  );

  // ----------------------------------------------------------------
  // Ingress buffer
  // ----------------------------------------------------------------
  // A word leaves when both sides agree
  assign pop = ing_valid & ing_ready;

  // Shift out on pop, then append the captured word behind the rest
  always_comb begin
    next_cnt    = ing_cnt;
    next_pos[0] = ent_pos[0];
    next_pos[1] = ent_pos[1];
    next_neg[0] = ent_neg[0];
    next_neg[1] = ent_neg[1];
    push_drop   = 1'b0;
    if (pop) begin
      next_pos[0] = ent_pos[1];
      next_neg[0] = ent_neg[1];
      next_cnt    = ing_cnt - 2'h1;
    end
    if (ing_if.strobe) begin
      if (next_cnt == BUF_DEPTH) begin
        push_drop = 1'b1;                      // Receiver stalled too long
      end else begin
        next_pos[next_cnt[0]] = ing_if.bits[0];
        // Single rail ignores the negative input entirely
        next_neg[next_cnt[0]] = (mode == TLPES_MODE_STS1) ? 1'b0 : ing_if.bits[1]; // RULE5
        next_cnt = next_cnt + 2'h1;
      end
    end
  end

  // Buffer state; outputs are the head entry registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ing_cnt    <= 2'h0;
      ent_pos[0] <= 1'h0;
      ent_pos[1] <= 1'h0;
      ent_neg[0] <= 1'h0;
      ent_neg[1] <= 1'h0;
      ing_valid  <= 1'h0;
    end else begin
      ing_cnt    <= next_cnt;
      ent_pos[0] <= next_pos[0];
      ent_pos[1] <= next_pos[1];
      ent_neg[0] <= next_neg[0];
      ent_neg[1] <= next_neg[1];
      ing_valid  <= next_cnt != 2'h0;
    end
  end

  // Head entry drives the ingress outputs directly
  assign ing_pos = ent_pos[0];
  assign ing_neg = ent_neg[0];

  // Overflow flag, a new event wins over the clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovf <= 1'h0;
    end else if (push_drop) begin
      ovf <= 1'h1;
    end else if (stat_clr_ovf) begin
      ovf <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Egress rails
  // ----------------------------------------------------------------
  // Egress launch edge choice from the settings
  assign eg_if.fall_sel = cfg[CFG_EG_FALL];    // RULE7 RULE9

  // Finds launch edges only; its data input is unused
  tlpes_edge_sampler #(.W(1)) u_eg (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_clk  (trib_tx_clock),
    .pin_data (1'b0),
    .port     (eg_if.sampler)
  );

  // Slot fills on a handshake and empties at each launch
  assign take           = eg_valid & eg_ready;
  assign next_hold_full = take | (hold_full & ~eg_if.strobe);

  // Holding slot, refilled by the sender between launch edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_full <= 1'h0;
      hold_pos  <= 1'h0;
      hold_neg  <= 1'h0;
      eg_ready  <= 1'h0;
    end else begin
      hold_full <= next_hold_full;
      eg_ready  <= ~next_hold_full;
      if (take) begin
        hold_pos <= eg_pos;
        hold_neg <= eg_neg;
      end
    end
  end

  // Launch on the chosen edge; an empty slot sends zeros
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trib_tx_pos_rail <= 1'h0;
      trib_tx_neg_rail <= 1'h0;
    end else if (eg_if.strobe) begin
      trib_tx_pos_rail <= hold_full & hold_pos;                  // RULE7 RULE9
      trib_tx_neg_rail <= (mode == TLPES_MODE_STS1) ? 1'b0 : (hold_full & hold_neg); // RULE8
    end else if (mode == TLPES_MODE_STS1) begin
      trib_tx_neg_rail <= 1'h0;                                   // RULE8
    end
  end

  // Underrun flag, a new event wins over the clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      und <= 1'h0;
    end else if (eg_if.strobe && !hold_full) begin
      und <= 1'h1;
    end else if (stat_clr_und) begin
      und <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Redundant copy follows its own sampler, like the primary one
  line_red_copy_a: assert property ( // RULE2
    red_if.strobe |=> line_red_strobe && line_red_bit == $past(red_if.bits[0]))
    else $error("redundant line capture lost");

  // Primary copy carries the bit captured at the edge
  line_pri_copy_a: assert property ( // RULE1
    pri_if.strobe |=> line_pri_strobe && line_pri_bit == $past(pri_if.bits[0]))
    else $error("primary line capture lost");

  // A settings write lands in the next cycle
  cfg_write_a: assert property ( // RULE3
    reg_wr && reg_addr == REG_CFG |=> cfg == $past(reg_wdata[CFG_W-1:0]))
    else $error("settings write not taken");

  // Settings leave reset as dual rail with rising edges
  cfg_reset_a: assert property ( // RULE11
    $fell(rst) |-> cfg == CFG_RESET)
    else $error("settings not rising after reset");

  // Single rail word holds the positive bit, negative low
  sts1_pos_kept_a: assert property ( // RULE6
    ing_if.strobe && ing_cnt == 2'h0 && mode == TLPES_MODE_STS1
      |=> ing_valid && ing_pos == $past(ing_if.bits[0]) && !ing_neg)
    else $error("single rail bit not captured");

  // Dual rail word keeps the negative bit
  ds3_neg_kept_a: assert property ( // RULE4
    ing_if.strobe && ing_cnt == 2'h0 && mode == TLPES_MODE_DS3E3
      |=> ing_valid && ing_neg == $past(ing_if.bits[1]))
    else $error("negative rail not captured");

  // Single rail never hands a set negative bit on
  sts1_neg_dropped_a: assert property ( // RULE5
    mode == TLPES_MODE_STS1 && $stable(cfg) [*2] |-> !(ing_valid && ing_neg))
    else $error("negative rail used in single rail");

  // A full slot goes out on the selected edge
  eg_launch_a: assert property ( // RULE7
    eg_if.strobe && hold_full |=> trib_tx_pos_rail == $past(hold_pos))
    else $error("egress bit not launched on edge");

  // Positive rail moves only on the selected edge, in either mode
  eg_quiet_a: assert property ( // RULE9
    !eg_if.strobe |=> $stable(trib_tx_pos_rail))
    else $error("egress changed off the edge");

  // Negative rail stays low in single rail
  sts1_neg_idle_a: assert property ( // RULE8
    mode == TLPES_MODE_STS1 |=> !trib_tx_neg_rail)
    else $error("negative rail driven in single rail");

  // Main scenarios reached
  buf_full_c: cover property (ing_cnt == BUF_DEPTH);
  sts1_egress_c: cover property (mode == TLPES_MODE_STS1 && eg_if.strobe && hold_full);
  fall_ingress_c: cover property (cfg[CFG_IN_FALL] && ing_if.strobe);
  underrun_c: cover property (eg_if.strobe && !hold_full);

endmodule // tlpes_top

// ==== hw/tlpes_pkg.sv ====
// Constants, field layout and mode type for the tributary line port.
// Assumes a single 25 MHz core clock and a plain strobe register port.
//
// Behaviour
// RULE1: Line data captured on line clock rising edge
// RULE2: Primary and redundant line inputs, same edge
// RULE3: Per-channel mode selects DS3/E3 or STS-1
// RULE4: DS3/E3 ingress samples both rails, selectable edge
// RULE5: STS-1 ingress uses positive rail only
// RULE6: STS-1 ingress samples on selectable edge
// RULE7: DS3/E3 egress launches both rails, selectable edge
// RULE8: STS-1 egress drives negative rail idle
// RULE9: STS-1 egress launches on selectable edge
// RULE10: Line unit holds data stable around chosen edge
// RULE11: Separate mode and edge settings, rising after reset
package tlpes_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 8;      // Register address width
  localparam int          DATA_W         = 32;     // Register data width
  localparam logic [7:0]  REG_CFG        = 8'h00;  // Mode and edge settings
  localparam logic [7:0]  REG_STAT       = 8'h04;  // Port state, sticky flags

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          CFG_MODE_BIT   = 0;      // 1 selects STS-1 single rail
  localparam int          CFG_IN_FALL    = 1;      // Ingress samples on falling edge
  localparam int          CFG_EG_FALL    = 2;      // Egress launches on falling edge
  localparam int          CFG_W          = 3;      // Width of the settings field
  localparam logic [2:0]  CFG_RESET      = 3'h0;   // DS3/E3, rising edges
  localparam int          STAT_CNT_LSB   = 0;      // Ingress buffer fill, 2 bits
  localparam int          STAT_OVF_BIT   = 2;      // Ingress overflow, sticky
  localparam int          STAT_UND_BIT   = 3;      // Egress underrun, sticky
  localparam int          STAT_MODE_BIT  = 4;      // Current mode echo

  // ----------------------------------------------------------------
  // Buffering and synchronisers
  // ----------------------------------------------------------------
  localparam logic [1:0]  BUF_DEPTH      = 2'h2;   // Ingress buffer entries

  // Channel operating mode
  typedef enum logic {TLPES_MODE_DS3E3, TLPES_MODE_STS1} tlpes_mode_t;

endpackage

// ==== hw/tlpes_samp_if.sv ====
// Link between the top module and one edge sampler.
// Assumes the edge selection is steady while the sampler runs.
`timescale 1ns/1ps

interface tlpes_samp_if #(parameter int W = 1);
  logic         fall_sel;  // High selects the falling edge
  logic         strobe;    // One-cycle pulse per captured edge
  logic [W-1:0] bits;      // Bits captured at that edge

  modport sampler (input fall_sel, output strobe, output bits);
  modport user    (output fall_sel, input strobe, input bits);
endinterface // tlpes_samp_if

// ==== hw/tlpes_edge_sampler.sv ====
// Samples an outside clock and data on core_clk and captures the data
// on the selected edge of that clock.
// Assumes the outside clock is well below half the core clock rate.
`timescale 1ns/1ps

module tlpes_edge_sampler
  import tlpes_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         pin_clk,
  input  wire logic [W-1:0] pin_data,
  tlpes_samp_if.sampler     port
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic         clk_s1, clk_s2, clk_s3;    // Clock pin stages
  logic [W-1:0] dat_s1, dat_s2, dat_s3;    // Data pin stages
  logic         edge_hit;                  // Selected edge seen

  // Two flops per pin, a third for edge detection and setup side data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_s1 <= 1'h0;
      clk_s2 <= 1'h0;
      clk_s3 <= 1'h0;
      dat_s1 <= '0;
      dat_s2 <= '0;
      dat_s3 <= '0;
    end else begin
      clk_s1 <= pin_clk;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= pin_data;
      dat_s2 <= dat_s1;
      dat_s3 <= dat_s2;
    end
  end

  // Rising or falling transition as chosen
  assign edge_hit = port.fall_sel ? (clk_s3 & ~clk_s2) : (~clk_s3 & clk_s2);

  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // Data from the cycle before the edge is seen, so a change right at
  // the edge (zero hold) does not leak into the captured value.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port.strobe <= 1'h0;
      port.bits   <= '0;
    end else begin
      port.strobe <= edge_hit;                    // RULE1
      if (edge_hit) begin
        port.bits <= dat_s3;                      // RULE6
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  edge_capture_a: assert property (@(posedge core_clk) disable iff (rst) // RULE1
    edge_hit |=> port.strobe && port.bits == $past(dat_s3))
    else $error("edge not captured with its data");
  no_stray_strobe_a: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    port.strobe |-> $past(port.fall_sel) ? $past(clk_s3 & ~clk_s2) : $past(~clk_s3 & clk_s2))
    else $error("strobe without the selected edge");

endmodule // tlpes_edge_sampler

// ==== testbench/tlpes_liu_model.sv ====
// Line interface unit model for the tributary side of the port.
// Assumes the bench calls rx_burst and tx_burst by hierarchical name.
`timescale 1ns/1ps

module tlpes_liu_model (
  input  wire logic in_fall,          // Device samples ingress on falling edge
  output logic      trib_rx_clock,    // Ingress clock, still between bursts
  output logic      trib_rx_pos_rail, // Ingress positive rail
  output logic      trib_rx_neg_rail, // Ingress negative rail
  output logic      trib_tx_clock     // Egress clock, still between bursts
);
  logic [1:0] word; // Word now on the ingress rails

  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial begin
    trib_rx_clock = 1'b0;
    trib_tx_clock = 1'b0;
    word = 2'h0;
    {trib_rx_neg_rail, trib_rx_pos_rail} = 2'h0;
  end

  // Toggles the ingress clock 2n-1 times, 320 ns period; new word on the
  // edge the device does not sample, so data stands still around its edge
  task automatic rx_burst(input int n);
    #7;
    for (int i = 0; i < 2 * n - 1; i++) begin
      #160 trib_rx_clock = ~trib_rx_clock;
      if (trib_rx_clock == in_fall) begin
        word = word + 2'h1;
        {trib_rx_neg_rail, trib_rx_pos_rail} = word;
      end
    end
  endtask

  // Toggles the egress clock 2n-1 times, 320 ns period
  task automatic tx_burst(input int n);
    #7;
    for (int i = 0; i < 2 * n - 1; i++) begin
      #160 trib_tx_clock = ~trib_tx_clock;
    end
  endtask
endmodule // tlpes_liu_model

// ==== testbench/tb_tlpes_top.sv ====
// Self-checking bench for the tributary line port.
// Assumes the line unit model drives the tributary clocks and rails.
`timescale 1ns/1ps

module tb_tlpes_top
  import tlpes_pkg::*;
;
  logic              core_clk  = 1'b0;
  logic              rst       = 1'b1;
  logic [ADDR_W-1:0] reg_addr  = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              lclk      = 1'b0; // Line clock for both inputs
  logic              ldat_p    = 1'b0; // Primary line data
  logic              ldat_r    = 1'b0; // Redundant line data
  logic              lstb_p, lbit_p, lstb_r, lbit_r;
  logic              trx_clk, trx_pos, trx_neg, ttx_clk, ttx_pos, ttx_neg;
  logic              ing_valid, ing_pos, ing_neg, eg_ready;
  logic              ing_ready = 1'b1;
  logic              eg_valid  = 1'b0;
  logic [1:0]        eg_word   = 2'h1; // {neg, pos} offered to egress
  logic              feed      = 1'b0; // Egress sender enabled
  logic              in_fall_m = 1'b0; // Ingress edge told to the model
  logic [1:0]        got_q[$];         // Words popped from ingress
  logic [1:0]        lp_q[$];          // Expected {red, pri} line bits
  int                tx_cnt    = 0;    // Egress words accepted
  int                lcnt      = 0;    // Line strobes seen
  int                fail_count      = 0;
  int                samples_checked = 0;

  always #20 core_clk = ~core_clk;

  tlpes_top i_dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .line_rx_serial_clock_diff_pri(lclk), .line_rx_serial_data_diff_pri(ldat_p),
    .line_rx_serial_clock_diff_red(lclk), .line_rx_serial_data_diff_red(ldat_r),
    .line_pri_strobe(lstb_p), .line_pri_bit(lbit_p),
    .line_red_strobe(lstb_r), .line_red_bit(lbit_r),
    .trib_rx_clock(trx_clk), .trib_rx_pos_rail(trx_pos), .trib_rx_neg_rail(trx_neg),
    .ing_valid(ing_valid), .ing_ready(ing_ready), .ing_pos(ing_pos), .ing_neg(ing_neg),
    .trib_tx_clock(ttx_clk), .eg_valid(eg_valid), .eg_ready(eg_ready),
    .eg_pos(eg_word[0]), .eg_neg(eg_word[1]),
    .trib_tx_pos_rail(ttx_pos), .trib_tx_neg_rail(ttx_neg));

  tlpes_liu_model i_liu (
    .in_fall(in_fall_m), .trib_rx_clock(trx_clk), .trib_rx_pos_rail(trx_pos),
    .trib_rx_neg_rail(trx_neg), .trib_tx_clock(ttx_clk));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Pops ingress words and checks both line outputs at each strobe
  always @(posedge core_clk) begin
    if (ing_valid === 1'b1 && ing_ready === 1'b1) got_q.push_back({ing_neg, ing_pos});
    if (lstb_p === 1'b1) begin
      lcnt++;
      check({lstb_r, lbit_r, lbit_p}, {1'b1, lp_q.pop_front()}, "line bits");
    end
  end

  // Egress sender: holds each word until the slot takes it
  always @(posedge core_clk) begin
    if (eg_valid === 1'b1 && eg_ready === 1'b1) begin
      tx_cnt <= tx_cnt + 1;
      eg_word <= eg_word + 2'h1;
    end
    if (eg_valid !== 1'b1 || eg_ready === 1'b1) eg_valid <= feed;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reg_test;
    logic [31:0] d;
    rd(REG_CFG, d); check(d, 32'h0, "cfg reset");
    wr(REG_CFG, 32'hFFFF_FFFF);
    rd(REG_CFG, d); check(d, 32'h7, "cfg fields");
    @(posedge core_clk);
    #1 check(reg_rdata, 32'h0, "rdata one cycle");
    rd(REG_STAT, d); check(d, 32'h10, "mode echo");
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, d); check(d, 32'h0, "unmapped read");
    wr(REG_CFG, 32'h0);
    $display("reg_test done");
  endtask

  task automatic line_test;
    #7;
    for (int k = 0; k < 8; k++) begin
      {ldat_r, ldat_p} = 2'(k);
      #160 lclk = 1'b1;
      lp_q.push_back(2'(k));
      #160 lclk = 1'b0;
    end
    repeat (8) @(posedge core_clk);
    check(lcnt, 8, "line strobes");
    $display("line_test done");
  endtask

  task automatic ingress_modes;
    logic mode, fall;
    int   n;
    for (int c = 0; c < 4; c++) begin
      mode = c[0]; fall = c[1];
      wr(REG_CFG, {30'h0, fall, mode});
      in_fall_m = fall;
      n = (trx_clk == fall) ? 4 : 3;
      got_q.delete();
      i_liu.rx_burst(4);
      repeat (8) @(posedge core_clk);
      check(got_q.size(), n, "ingress count");
      if (mode) check(got_q[0][1], 1'b0, "neg ignored");
      for (int i = 1; i < got_q.size(); i++)
        check(got_q[i], mode ? {1'b0, ~got_q[i-1][0]} : 2'(got_q[i-1] + 2'h1),
              "word");
    end
    $display("ingress_modes done");
  endtask

  task automatic overflow_test;
    logic [31:0] d;
    wr(REG_CFG, 32'h0);
    in_fall_m = 1'b0;
    ing_ready <= 1'b0;
    got_q.delete();
    i_liu.rx_burst(4);
    repeat (8) @(posedge core_clk);
    rd(REG_STAT, d); check(d, 32'h6, "full and overflow");
    @(posedge core_clk);
    ing_ready <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(got_q.size(), 2, "words kept");
    check(got_q[1], 2'(got_q[0] + 2'h1), "fifo order");
    wr(REG_STAT, 32'h4);
    rd(REG_STAT, d); check(d, 32'h0, "overflow cleared");
    $display("overflow_test done");
  endtask

  task automatic egress_modes;
    logic       mode, fall;
    logic [1:0] last;
    int         n, start;
    for (int c = 0; c < 4; c++) begin
      mode = c[0]; fall = c[1];
      wr(REG_CFG, {29'h0, fall, 1'b0, mode});
      feed <= 1'b1;
      repeat (4) @(posedge core_clk);
      n = (ttx_clk == fall) ? 3 : 2;
      start = tx_cnt;
      i_liu.tx_burst(3);
      repeat (8) @(posedge core_clk);
      check(tx_cnt - start, n, "egress count");
      last = 2'(tx_cnt - 1);
      check({ttx_neg, ttx_pos}, mode ? {1'b0, last[0]} : last, "rails");
    end
    $display("egress_modes done");
  endtask

  task automatic underrun_test;
    logic [31:0] d;
    feed <= 1'b0;
    i_liu.tx_burst(4);
    repeat (8) @(posedge core_clk);
    check({ttx_neg, ttx_pos}, 2'h0, "idle rails");
    rd(REG_STAT, d); check(d[STAT_UND_BIT], 1'b1, "underrun flag");
    wr(REG_STAT, 32'h8);
    rd(REG_STAT, d); check(d[STAT_UND_BIT], 1'b0, "underrun cleared");
    $display("underrun_test done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    reg_test();
    line_test();
    ingress_modes();
    overflow_test();
    egress_modes();
    underrun_test();
    final_report();
  end

  // Watchdog, far beyond the expected run of about 20 us
  initial begin
    #300000;
    fail_count++;
    final_report();
  end
endmodule // tb_tlpes_top
